/* File: pfc_pkg.sv */
package pfc_pkg;
   localparam logic [11:0] FC0_OFFSET = 12'h1A8;
   localparam int BP_BIT = 6;
   localparam int DUP_BIT = 5;
   localparam int CRX_BIT = 4;
   localparam int CTX_BIT = 3;
   localparam int RX_BIT = 2;
   localparam int TX_BIT = 1;
   localparam int SEL_BIT = 0;
   localparam int REG_W = 32;
   localparam logic [31:0] RSVD_MASK = 32'hFFFF_FF80;
endpackage

/* File: pfc_resolve.sv */
// resolves the pause enables actually in effect on port 0
module pfc_resolve (
   input wire logic sel,
   input wire logic rx_en,
   input wire logic tx_en,
   input wire logic an_enable,
   input wire logic an_rx_pause,
   input wire logic an_tx_pause,
   input wire logic half_duplex,
   output logic rx_act,
   output logic tx_act
);
   always_comb
   begin
      // pause is a full-duplex mechanism only
      if (half_duplex)
      begin
         rx_act = 1'h0;
         tx_act = 1'h0;
      end
      else if (sel || !an_enable)
      begin
         rx_act = rx_en;
         tx_act = tx_en;
      end
      else
      begin
         rx_act = an_rx_pause;
         tx_act = an_tx_pause;
      end
   end
endmodule

/* File: pfc_reg.sv */
// Operation
// - bit 6 enables half-duplex backpressure
// - bit 5 reports duplex, one half
// - bit 4 reports active receive pause
// - bit 3 reports active transmit pause
// - bit 2 manual receive pause enable
// - bit 1 manual transmit pause enable
// - select clear: negotiation rules unless disabled
// - select set: manual bits rule full duplex
// - MAC mode holds select at one
// - MAC mode makes select read-only
// - MAC mode select ignores loader rewrite
// - writable defaults come from straps, reloaded
// - status defaults from straps, refreshed
// - writes never touch advertisement register
module pfc_reg #(
   parameter int ADDR_W = $bits(pfc_pkg::FC0_OFFSET),
   parameter int DATA_W = pfc_pkg::REG_W
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic mac_mode,
   input wire logic strap_load,
   input wire logic backpressure_default_strap,
   input wire logic pause_default_strap,
   input wire logic override_default_strap,
   input wire logic strap_half_duplex,
   input wire logic an_enable,
   input wire logic an_rx_pause,
   input wire logic an_tx_pause,
   input wire logic link_half_duplex,
   output logic port0_backpressure_enable,
   output logic port0_resolved_duplex,
   output logic port0_resolved_rx_pause,
   output logic port0_resolved_tx_pause
);
   ////////////////////////////////////////////////////////////////////////
   // host-visible configuration, loaded from straps or written by the host
   logic bp_q, bp_d, rx_q, rx_d, tx_q, tx_d, sel_q, sel_d;
   // resolved status as the port currently applies it
   logic dup_q, dup_d, crx_q, crx_d, ctx_q, ctx_d;
   logic [DATA_W-1:0] rd_q, rd_d;
   // straps are sampled on the first clock after release, and on each rewrite
   logic init_q, init_d, load_q, load_d;
   logic reload, wr_hit, rd_hit, rx_act, tx_act;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
      addr_hit = (addr == ADDR_W'(pfc_pkg::FC0_OFFSET));
   endfunction

   assign wr_hit = addr_hit(reg_addr) && reg_wr;
   assign rd_hit = addr_hit(reg_addr) && reg_rd;
   assign reload = init_q || load_q;

   ////////////////////////////////////////////////////////////////////////
   // the loader pulse is registered, so a rewrite lands one clock later
   always_comb
   begin
      init_d = 1'h0;
      load_d = strap_load;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         init_q <= 1'h1;
         load_q <= 1'h0;
      end
      else
      begin
         init_q <= init_d;
         load_q <= load_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      bp_d = bp_q;
      rx_d = rx_q;
      tx_d = tx_q;
      sel_d = sel_q;
      // a loader rewrite beats a host write in the same cycle
      if (reload)
      begin
         bp_d = backpressure_default_strap;
         rx_d = pause_default_strap;
         tx_d = pause_default_strap;
         sel_d = override_default_strap;
      end
      else if (wr_hit)
      begin
         bp_d = reg_wdata[pfc_pkg::BP_BIT];
         rx_d = reg_wdata[pfc_pkg::RX_BIT];
         tx_d = reg_wdata[pfc_pkg::TX_BIT];
         sel_d = reg_wdata[pfc_pkg::SEL_BIT];
      end
      // no negotiation partner exists in mac mode, so manual is forced
      if (mac_mode)
      begin
         sel_d = 1'h1;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         bp_q <= '0;
         rx_q <= '0;
         tx_q <= '0;
         sel_q <= '0;
      end
      else
      begin
         bp_q <= bp_d;
         rx_q <= rx_d;
         tx_q <= tx_d;
         sel_q <= sel_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fed the next duplex so the pause status never lags the duplex bit
   pfc_resolve u_res (
      .sel(sel_q),
      .rx_en(rx_q),
      .tx_en(tx_q),
      .an_enable(an_enable),
      .an_rx_pause(an_rx_pause),
      .an_tx_pause(an_tx_pause),
      .half_duplex(dup_d),
      .rx_act(rx_act),
      .tx_act(tx_act)
   );

   always_comb
   begin
      // strap duplex at load time, the live link afterwards
      dup_d = link_half_duplex;
      if (reload)
      begin
         dup_d = strap_half_duplex;
      end
      crx_d = rx_act;
      ctx_d = tx_act;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         dup_q <= '0;
         crx_q <= '0;
         ctx_q <= '0;
      end
      else
      begin
         dup_q <= dup_d;
         crx_q <= crx_d;
         ctx_q <= ctx_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      rd_d = '0;
      if (rd_hit)
      begin
         rd_d[pfc_pkg::BP_BIT] = bp_q;
         rd_d[pfc_pkg::DUP_BIT] = dup_q;
         rd_d[pfc_pkg::CRX_BIT] = crx_q;
         rd_d[pfc_pkg::CTX_BIT] = ctx_q;
         rd_d[pfc_pkg::RX_BIT] = rx_q;
         rd_d[pfc_pkg::TX_BIT] = tx_q;
         rd_d[pfc_pkg::SEL_BIT] = sel_q;
      end
   end

   // read data drops back to zero, so a stale word never lingers on the bus
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rd_q <= '0;
      else
         rd_q <= rd_d;
   end

   // no path to any advertisement state exists here
   assign reg_rdata = rd_q;
   assign port0_backpressure_enable = bp_q;
   assign port0_resolved_duplex = dup_q;
   assign port0_resolved_rx_pause = crx_q;
   assign port0_resolved_tx_pause = ctx_q;

   ////////////////////////////////////////////////////////////////////////
   a_mac_sel_high: assert property (
      $past(mac_mode) && !$past(rst) |-> sel_q)
      else $error("select not one in mac mode");
   a_mac_write_ro: assert property (
      mac_mode && wr_hit |=> sel_q)
      else $error("select written in mac mode");
   a_write_bp: assert property (
      wr_hit && !reload |=> bp_q == $past(reg_wdata[pfc_pkg::BP_BIT]))
      else $error("backpressure write lost");
   a_load_strap: assert property (
      load_q |=> bp_q == $past(backpressure_default_strap)
      && rx_q == $past(pause_default_strap))
      else $error("strap reload missed");
   a_load_sel: assert property (
      reload |=> sel_q == ($past(mac_mode) || $past(override_default_strap)))
      else $error("select default wrong after strap load");
   a_rsvd_zero: assert property (
      (reg_rdata & DATA_W'(pfc_pkg::RSVD_MASK)) == '0)
      else $error("reserved bits nonzero");
   a_idle_zero: assert property (
      !rd_hit |=> reg_rdata == '0)
      else $error("read data not cleared");
   a_manual_rx: assert property (
      sel_q && !dup_d |=> crx_q == $past(rx_q))
      else $error("manual rx not applied");
   a_manual_tx: assert property (
      sel_q && !dup_d |=> ctx_q == $past(tx_q))
      else $error("manual tx not applied");
   a_auto_tx: assert property (
      !sel_q && an_enable && !dup_d |=> ctx_q == $past(an_tx_pause))
      else $error("negotiated tx not applied");
   a_noneg_rx: assert property (
      !sel_q && !an_enable && !dup_d |=> crx_q == $past(rx_q))
      else $error("manual rx not applied without negotiation");
   a_half_off: assert property (
      dup_d |=> !crx_q && !ctx_q)
      else $error("pause active in half duplex");
   a_read_dup: assert property (
      rd_hit |=> reg_rdata[pfc_pkg::DUP_BIT] == $past(dup_q))
      else $error("duplex readback wrong");
   a_read_status: assert property (
      rd_hit |=> reg_rdata[pfc_pkg::CRX_BIT] == $past(crx_q)
      && reg_rdata[pfc_pkg::CTX_BIT] == $past(ctx_q))
      else $error("pause status readback wrong");
   c_write: cover property (wr_hit);
   c_load: cover property (load_q);
   c_mac: cover property (mac_mode && wr_hit);
   c_half_bp: cover property (dup_q && bp_q);
   c_auto_rx: cover property (!sel_q && an_enable && crx_q);
endmodule

/* File: tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] A = pfc_pkg::FC0_OFFSET;
   logic clock = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
   logic mac_mode = 1'h0, strap_load = 1'h0, strap_half_duplex = 1'h0;
   logic link_half_duplex = 1'h0;
   logic backpressure_default_strap = 1'h1, pause_default_strap = 1'h1;
   logic override_default_strap = 1'h0, an_enable = 1'h1;
   logic an_rx_pause = 1'h0, an_tx_pause = 1'h0;
   logic [11:0] reg_addr = A;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_v;
   logic port0_backpressure_enable, port0_resolved_duplex;
   logic port0_resolved_rx_pause, port0_resolved_tx_pause;
   int miscompares = 0, checks_done = 0;
   pfc_reg dut (.clock, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata, .mac_mode, .strap_load, .backpressure_default_strap,
      .pause_default_strap, .override_default_strap, .strap_half_duplex,
      .an_enable, .an_rx_pause, .an_tx_pause, .link_half_duplex,
      .port0_backpressure_enable, .port0_resolved_duplex,
      .port0_resolved_rx_pause, .port0_resolved_tx_pause);
   initial forever #50 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////
   task give_verdict;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task rd(input logic [11:0] a);
      @(posedge clock) reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clock) reg_rd <= 1'h0;
      reg_addr <= A;
      #1 rd_v = reg_rdata;
   endtask
   task wr(input logic [31:0] d);
      @(posedge clock) reg_wr <= 1'h1;
      reg_wdata <= d;
      @(posedge clock) reg_wr <= 1'h0;
      repeat (2) @(posedge clock);
   endtask
   // register and output pins must agree with the same expectation
   task chk(input string n, input logic [31:0] e);
      rd(A);
      cmp(n, e, rd_v);
      cmp({n, " pins"}, {28'h0, e[6:3]}, {28'h0, port0_backpressure_enable,
         port0_resolved_duplex, port0_resolved_rx_pause,
         port0_resolved_tx_pause});
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_manual;
      wr(32'hFFFF_FFFF);
      chk("manual full", 32'h0000_005F);
      @(posedge clock) link_half_duplex <= 1'h1;
      repeat (3) @(posedge clock);
      chk("manual half", 32'h0000_0067);
      @(posedge clock) link_half_duplex <= 1'h0;
      rd(12'h1AC);
      cmp("unmapped", 32'h0, rd_v);
      $display("test manual done");
   endtask
   task t_negotiated;
      @(posedge clock) an_enable <= 1'h0;
      wr(32'h0000_0006);
      chk("an off", 32'h0000_001E);
      @(posedge clock) an_enable <= 1'h1;
      an_rx_pause <= 1'h1;
      repeat (3) @(posedge clock);
      chk("an on", 32'h0000_0016);
      $display("test negotiated done");
   endtask
   task t_mac;
      // loader reload in mac mode must not clear the select bit
      @(posedge clock) mac_mode <= 1'h1;
      strap_load <= 1'h1;
      strap_half_duplex <= 1'h1;
      @(posedge clock) strap_load <= 1'h0;
      // strap duplex shows for one clock, until the live link takes over
      @(posedge clock);
      @(negedge clock);
      cmp("strap duplex", 32'h0000_0001,
         {31'h0, port0_resolved_duplex});
      repeat (2) @(posedge clock);
      chk("mac reload", 32'h0000_005F);
      wr(32'h0000_0000);
      chk("mac write", 32'h0000_0001);
      $display("test mac done");
   endtask
   initial
   begin
      repeat (8) @(posedge clock);
      rst <= 1'h0;
      repeat (2) @(posedge clock);
      chk("reset", 32'h0000_0046);
      $display("test reset done");
      t_manual();
      t_negotiated();
      t_mac();
      give_verdict();
   end
   // the scenarios need under 100 clocks; ten times that means a hang
   initial
   begin
      repeat (1000) @(posedge clock);
      miscompares++;
      give_verdict();
   end
endmodule
